// *** shared/ssw_pkg.sv ***
// constants, state codes and helpers shared by the supply supervisor
package ssw_pkg;

  // clock and divider
  localparam int unsigned CLK_HZ = 25_000_000; // ref_clk rate
  localparam int unsigned CLK_PERIOD_NS = 40; // ref_clk period
  localparam int unsigned TICK_US = 1000; // slow tick period, 1 ms
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

  // reset hold period in ms ticks
  localparam int unsigned HOLD_SHORT_MS = 150;
  localparam int unsigned HOLD_LONG_MS = 600;

  // watchdog periods in ms ticks
  localparam int unsigned WD_SHORT_MS = 150;
  localparam int unsigned WD_MID_MS = 400;
  localparam int unsigned WD_LONG_MS = 800;

  // low-line to reset delay on power-down
  localparam int unsigned LR_DELAY_NS = 200;
  localparam int unsigned LR_CYCLES = (LR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LR_W = 3; // lr counter width

  // manual reset input must sit still this long
  localparam int unsigned DEBOUNCE_MS = 10;

  // width of the hold and watchdog ms counters
  localparam int unsigned MS_W = 10;

  // watchdog period select codes {hi, lo}
  localparam logic [1:0] WD_CODE_150 = 2'h2;
  localparam logic [1:0] WD_CODE_400 = 2'h1;
  localparam logic [1:0] WD_CODE_800 = 2'h0;
  localparam logic [1:0] WD_CODE_OFF = 2'h3;
  localparam logic [1:0] WD_SEL_RESET = WD_CODE_OFF; // factory default: disabled

  // register map
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int unsigned CTRL_LONG_BIT = 0;
  localparam logic CTRL_LONG_RESET = 1'h0;
  localparam int unsigned STAT_RESET_BIT = 0;
  localparam int unsigned STAT_LOWLINE_BIT = 1;
  localparam int unsigned STAT_SFAIL_BIT = 2;
  localparam int unsigned STAT_BATT_BIT = 3;
  localparam int unsigned STAT_WDOG_BIT = 4;
  localparam int unsigned STAT_BACKUP_BIT = 5;
  localparam int unsigned STAT_WD_LO_BIT = 8;
  localparam int unsigned STAT_WD_HI_BIT = 9;

  // synchroniser lane positions
  localparam int unsigned SYN_PRI = 0;
  localparam int unsigned SYN_SEC = 1;
  localparam int unsigned SYN_BOK = 2;
  localparam int unsigned SYN_BLO = 3;
  localparam int unsigned SYN_BHI = 4;
  localparam int unsigned SYN_V1 = 5;
  localparam int unsigned SYN_MR = 6;
  localparam int unsigned SYN_SCL = 7;
  localparam int unsigned SYN_SDA = 8;
  localparam int unsigned SYN_N = 9;
  localparam logic [8:0] SYN_RESET = 9'h1c0; // button, scl, sda idle high

  // supervisor states
  typedef enum logic [2:0] {
    SSW_HOLD = 3'h1,
    SSW_RUN = 3'h2,
    SSW_DROP = 3'h4
  } ssw_state_t;

  // watchdog limit in ms ticks, zero when disabled
  function automatic logic [MS_W-1:0] ssw_wd_limit(input logic [1:0] sel);
    case (sel)
      WD_CODE_150: ssw_wd_limit = MS_W'(WD_SHORT_MS);
      WD_CODE_400: ssw_wd_limit = MS_W'(WD_MID_MS);
      WD_CODE_800: ssw_wd_limit = MS_W'(WD_LONG_MS);
      default: ssw_wd_limit = '0;
    endcase
  endfunction

  // reset hold limit in ms ticks
  function automatic logic [MS_W-1:0] ssw_hold_limit(input logic long_sel);
    ssw_hold_limit = long_sel ? MS_W'(HOLD_LONG_MS) : MS_W'(HOLD_SHORT_MS);
  endfunction

endpackage

// *** logic/ssw_debounce.sv ***
// debouncer for the manual reset button
`timescale 1ns/100ps
module ssw_debounce #(
  parameter int unsigned STABLE_MS = ssw_pkg::DEBOUNCE_MS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic raw_n,
  output logic clean_n
);
  import ssw_pkg::*;

  localparam int unsigned CW = $clog2(STABLE_MS + 1);

  logic [CW-1:0] still_cnt; // ms ticks the input has differed from clean_n

  // clean edges: level must differ for STABLE_MS ticks before it is taken
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      still_cnt <= '0;
      clean_n <= 1'h1;
    end else if (raw_n == clean_n) begin
      // bounce back resets the wait
      still_cnt <= '0;
    end else if (tick) begin
      if (still_cnt == CW'(STABLE_MS - 1)) begin
        clean_n <= raw_n;
        still_cnt <= '0;
      end else begin
        still_cnt <= still_cnt + 1'b1;
      end
    end
  end

endmodule // ssw_debounce

// *** logic/ssw_supervisor.sv ***
// supply supervisor: reset, low-line, second supply, battery path, watchdog
`timescale 1ns/100ps
// Function
// - config bit picks 150 or 600 ms hold
// - low-line follows primary drop within 20 us
// - reset follows low-line by 200 ns
// - second fail follows second supply level
// - freeze second monitor when primary and battery low
// - battery path low while primary feeds output
// - two-bit field picks 150/400/800 ms watchdog
// - first scl fall after start restarts watchdog
// - expired watchdog drives its output active
// - period bits writable, default watchdog disabled
// - backup mode stops and clears watchdog count
// - power-on reset until primary held good
// - primary drop asserts reset, hold on return
// - ignore bus during low-supply reset
// - reset held while supply below 1 V
// - backup mode keeps reset, refuses bus
// - battery switch with 60 mV hysteresis
// - manual reset asserts, hold after release
// - manual reset input is debounced
module ssw_supervisor #(
  parameter int unsigned TICK_CYCLES_P = ssw_pkg::TICK_CYCLES,
  parameter int unsigned DEBOUNCE_MS_P = ssw_pkg::DEBOUNCE_MS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic primary_supply_sense,
  input wire logic second_supply_sense,
  input wire logic backup_cell_ok,
  input wire logic primary_below_batt,
  input wire logic primary_above_batt,
  input wire logic supply_above_1v,
  input wire logic manual_reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [ssw_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ssw_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ssw_pkg::DATA_W-1:0] reg_rdata,
  output logic reset_out_n,
  output logic lowline_n,
  output logic second_supply_fail_n,
  output logic batt_path,
  output logic watchdog_expired_n
);
  import ssw_pkg::*;

  localparam int unsigned TW = $clog2(TICK_CYCLES_P);

  // synchroniser stages
  logic [SYN_N-1:0] sync_a; // first stage, read only by sync_b
  logic [SYN_N-1:0] sync_b; // usable, settled copy
  logic [SYN_N-1:0] sync_p; // one cycle older, for edges

  // slow tick
  logic [TW-1:0] tick_cnt;
  logic tick;

  // supervisor state
  ssw_state_t state;
  ssw_state_t next_state;
  logic [MS_W-1:0] hold_cnt; // ms ticks with release conditions met
  logic [LR_W-1:0] lr_cnt; // cycles spent in the drop window
  logic mr_clean; // debounced button, low = pressed

  // software-visible settings
  logic ctrl_long; // long hold select
  logic [1:0] wd_sel; // {hi, lo} period code

  // watchdog
  logic [MS_W-1:0] wd_cnt; // ms ticks since the last restart
  logic start_seen; // start seen, waiting for the scl fall

  // two-stage sync of every asynchronous input
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_a <= SYN_RESET;
      sync_b <= SYN_RESET;
      sync_p <= SYN_RESET;
    end else begin
      sync_a <= {sda_in, scl_in, manual_reset_n, supply_above_1v, primary_above_batt,
                 primary_below_batt, backup_cell_ok, second_supply_sense,
                 primary_supply_sense};
      sync_b <= sync_a;
      sync_p <= sync_b;
    end
  end

  wire logic pri_s = sync_b[SYN_PRI]; // primary above trip
  wire logic sec_s = sync_b[SYN_SEC]; // second supply above trip
  wire logic bok_s = sync_b[SYN_BOK]; // cell above trip
  wire logic blo_s = sync_b[SYN_BLO]; // primary under the cell band
  wire logic bhi_s = sync_b[SYN_BHI]; // primary over the cell band
  wire logic v1_s = sync_b[SYN_V1]; // core supply valid
  wire logic mr_s = sync_b[SYN_MR]; // button, low = pressed
  wire logic scl_s = sync_b[SYN_SCL];
  wire logic sda_s = sync_b[SYN_SDA];
  wire logic scl_p = sync_p[SYN_SCL]; // one cycle older, for edges
  wire logic sda_p = sync_p[SYN_SDA];

  // 1 ms enable pulse; all long timing runs on it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
      tick <= 1'h0;
    end else if (tick_cnt == TW'(TICK_CYCLES_P - 1)) begin
      tick_cnt <= '0;
      tick <= 1'h1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'h0;
    end
  end

  // button cleanup before it can touch reset
  ssw_debounce #(
    .STABLE_MS(DEBOUNCE_MS_P)
  ) u_mr_debounce (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick),
    .raw_n(mr_s),
    .clean_n(mr_clean)
  );

  // switchover with hysteresis: between the two comparators keep the source
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      batt_path <= 1'h0;
    end else if (blo_s) begin
      batt_path <= 1'h1;
    end else if (bhi_s) begin
      batt_path <= 1'h0;
    end
  end

  // indicator is the source flop itself, low while primary feeds output
  // backup mode: primary under trip and under the cell
  wire logic backup = !pri_s && batt_path;
  // second monitor is unpowered once both primary and cell are low
  wire logic mon_on = pri_s || bok_s;
  // release needs good primary, released button, valid core supply
  wire logic release_ok = pri_s && mr_clean && v1_s && !backup;
  // hold length from the config bit
  wire logic [MS_W-1:0] hold_ms = ssw_hold_limit(ctrl_long);

  // supervisor next state
  always_comb begin
    next_state = state;
    case (state)
      SSW_HOLD: begin
        // leave only after a full hold with primary good
        if (release_ok && hold_cnt >= hold_ms) begin
          next_state = SSW_RUN;
        end
      end
      SSW_RUN: begin
        // button and core supply act at once
        if (!mr_clean || !v1_s) begin
          next_state = SSW_HOLD;
        end else if (!pri_s) begin
          next_state = SSW_DROP;
        end
      end
      SSW_DROP: begin
        if (!mr_clean || !v1_s) begin
          next_state = SSW_HOLD;
        end else if (pri_s) begin
          // glitch shorter than the delay, reset never drops
          next_state = SSW_RUN;
        end else if (lr_cnt == LR_W'(LR_CYCLES - 1)) begin
          // reset after the low-line lead time
          next_state = SSW_HOLD;
        end
      end
      default: begin
        next_state = SSW_HOLD;
      end
    endcase
  end

  // state register; power-on lands in hold
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= SSW_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // hold counter restarts whenever a release condition is lost
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_cnt <= '0;
    end else if (state != SSW_HOLD || !release_ok) begin
      hold_cnt <= '0;
    end else if (tick && hold_cnt < hold_ms) begin
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

  // drop window counter, cycles since low-line fell
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lr_cnt <= '0;
    end else if (state == SSW_DROP) begin
      lr_cnt <= lr_cnt + 1'b1;
    end else begin
      lr_cnt <= '0;
    end
  end

  // reset output from the state decision; low from power-on
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reset_out_n <= 1'h0;
    end else begin
      reset_out_n <= (next_state != SSW_HOLD);
    end
  end

  // low-line tracks primary, three cycles after the pin
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lowline_n <= 1'h0;
    end else begin
      lowline_n <= pri_s;
    end
  end

  // second fail follows its comparator while powered
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      second_supply_fail_n <= 1'h1;
    end else if (mon_on) begin
      second_supply_fail_n <= sec_s;
    end
  end

  // bus watched only with primary good and no reset hold
  wire logic bus_ok = pri_s && (state != SSW_HOLD);
  // start: sda falls while scl stays high
  wire logic start_cond = scl_s && scl_p && sda_p && !sda_s;
  // restart on first scl fall after a start
  wire logic wd_restart = bus_ok && start_seen && scl_p && !scl_s;

  // start latch, dropped after use or when the bus is ignored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      start_seen <= 1'h0;
    end else if (!bus_ok || wd_restart) begin
      start_seen <= 1'h0;
    end else if (start_cond) begin
      start_seen <= 1'h1;
    end
  end

  // period from the two-bit code; code 11 disables
  wire logic [MS_W-1:0] wd_lim = ssw_wd_limit(wd_sel);
  wire logic wd_on = (wd_sel != WD_CODE_OFF);

  // count cleared and frozen in backup, resumes with primary
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_cnt <= '0;
    end else if (backup || !wd_on || wd_restart) begin
      wd_cnt <= '0;
    end else if (tick && wd_cnt < wd_lim) begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // expiry drives the output low until the next restart, backup mode or disable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      watchdog_expired_n <= 1'h1;
    end else if (backup || !wd_on || wd_restart) begin
      watchdog_expired_n <= 1'h1;
    end else if (wd_cnt >= wd_lim) begin
      watchdog_expired_n <= 1'h0;
    end
  end

  // settings writes; period defaults to disabled
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_long <= CTRL_LONG_RESET;
      wd_sel <= WD_SEL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        ctrl_long <= reg_wdata[CTRL_LONG_BIT];
      end else if (reg_addr == REG_STAT) begin
        wd_sel <= reg_wdata[STAT_WD_HI_BIT:STAT_WD_LO_BIT];
      end
    end
  end

  // read data stands for one cycle only; unmapped reads zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd && reg_addr == REG_CTRL) begin
        reg_rdata[CTRL_LONG_BIT] <= ctrl_long;
      end else if (reg_rd && reg_addr == REG_STAT) begin
        reg_rdata[STAT_RESET_BIT] <= !reset_out_n;
        reg_rdata[STAT_LOWLINE_BIT] <= !lowline_n;
        reg_rdata[STAT_SFAIL_BIT] <= !second_supply_fail_n;
        reg_rdata[STAT_BATT_BIT] <= batt_path;
        reg_rdata[STAT_WDOG_BIT] <= !watchdog_expired_n;
        reg_rdata[STAT_BACKUP_BIT] <= backup;
        reg_rdata[STAT_WD_HI_BIT:STAT_WD_LO_BIT] <= wd_sel;
      end
    end
  end

  // checks on the supervisor
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_lowline_drop:
    assert property ($fell(pri_s) |=> !lowline_n ##0 $past(lowline_n, 2))
      else $error("low-line did not follow primary drop");
  a_reset_lead:
    assert property (($fell(lowline_n) && reset_out_n && mr_clean && v1_s)
                     ##1 (!lowline_n && mr_clean && v1_s)[*5] |-> !reset_out_n)
      else $error("reset not asserted 5 cycles after low-line");
  a_reset_no_early:
    assert property (($fell(lowline_n) && reset_out_n) ##1 (mr_clean && v1_s)[*4]
                     |-> reset_out_n && $past(reset_out_n, 3))
      else $error("reset asserted before low-line lead time");
  a_hold_release:
    assert property ($rose(reset_out_n) |-> $past(hold_cnt) >= $past(hold_ms)
                     && $past(hold_cnt) != '0)
      else $error("reset released before hold period");
  a_manual_reset:
    assert property (!mr_clean |=> !reset_out_n)
      else $error("manual reset did not assert reset");
  a_sfail_follow:
    assert property (mon_on && !sec_s |=> !second_supply_fail_n)
      else $error("second fail not asserted");
  a_sfail_freeze:
    assert property (!mon_on |=> $stable(second_supply_fail_n))
      else $error("second monitor changed while unpowered");
  a_batt_hyst:
    assert property (!blo_s && !bhi_s |=> $stable(batt_path))
      else $error("battery path moved inside hysteresis band");
  a_wd_backup:
    assert property (backup |=> wd_cnt == '0 && watchdog_expired_n)
      else $error("watchdog ran in backup mode");
  a_wd_restart:
    assert property (start_cond && bus_ok ##1 (scl_s && bus_ok)[*2] ##1 (!scl_s && bus_ok)
                     |=> wd_cnt == '0)
      else $error("watchdog not restarted after start");
  a_bus_ignored:
    assert property (!pri_s |-> !wd_restart ##1 !start_seen)
      else $error("bus seen during low-supply reset");
  a_wd_off:
    assert property (wd_sel == WD_CODE_OFF |=> watchdog_expired_n && wd_cnt == '0)
      else $error("disabled watchdog fired");

endmodule // ssw_supervisor

// *** tb/ssw_host_model.sv ***
// host model: issues bus start sequences that restart the watchdog
`timescale 1ns/100ps
module ssw_host_model #(
  parameter int unsigned GAP_CYCLES = 1000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic kick,
  input wire logic auto_kick,
  output logic scl,
  output logic sda
);
  logic [3:0] step; // phase of the current bus sequence, 0 = idle
  logic [15:0] gap; // spacing counter for periodic restarts

  // walk start, clock low, clock high, stop; start lasts 3 cycles, the others 4, so the
  // two-stage synchroniser on the far side cannot miss it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      step <= 4'h0;
      gap <= 16'h0;
    end else begin
      gap <= (gap == 16'(GAP_CYCLES - 1)) ? 16'h0 : gap + 16'h1;
      if (step != 4'h0) begin
        step <= step + 4'h1; // wraps back to idle after the stop
      end else if (kick || (auto_kick && gap == 16'h0)) begin
        step <= 4'h1;
      end
    end
  end

  // lines idle high through their pull-ups; sda only moves while scl is high at start/stop
  assign sda = !(step >= 4'h1 && step < 4'hc);
  assign scl = !(step >= 4'h4 && step < 4'h8);
endmodule // ssw_host_model

// *** tb/tb_top.sv ***
// self-checking bench for the supply supervisor
`timescale 1ns/100ps
module tb_top;
  import ssw_pkg::*;
  localparam int TK = 10; // clock cycles per slow tick in simulation
  localparam int LIMIT = 60000; // run needs about 35000 cycles
  // one register access and the read value it should give
  typedef struct {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic [31:0] mask;
    logic [31:0] exp;
  } ssw_row_t;
  logic ref_clk, rst; // clock and reset
  logic primary_supply_sense, second_supply_sense, backup_cell_ok; // comparators
  logic primary_below_batt, primary_above_batt, supply_above_1v; // comparators
  logic manual_reset_n, scl_in, sda_in, kick, auto_kick; // button and bus
  logic [7:0] reg_addr; // register port
  logic [31:0] reg_wdata, reg_rdata, got;
  logic reg_wr, reg_rd;
  logic reset_out_n, lowline_n, second_supply_fail_n, batt_path, watchdog_expired_n;
  int fails = 0; // mismatches seen
  int tests_run = 0; // comparisons made
  int cycles = 0; // hang guard
  ssw_row_t rows [12];
  logic [1:0] codes [3];
  int lims [3];

  ssw_supervisor #(.TICK_CYCLES_P(TK), .DEBOUNCE_MS_P(2)) dut (.ref_clk(ref_clk), .rst(rst),
    .primary_supply_sense(primary_supply_sense), .second_supply_sense(second_supply_sense),
    .backup_cell_ok(backup_cell_ok), .primary_below_batt(primary_below_batt),
    .primary_above_batt(primary_above_batt), .supply_above_1v(supply_above_1v),
    .manual_reset_n(manual_reset_n), .scl_in(scl_in), .sda_in(sda_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reset_out_n(reset_out_n), .lowline_n(lowline_n),
    .second_supply_fail_n(second_supply_fail_n), .batt_path(batt_path),
    .watchdog_expired_n(watchdog_expired_n));

  ssw_host_model #(.GAP_CYCLES(1000)) host (.ref_clk(ref_clk), .rst(rst), .kick(kick),
    .auto_kick(auto_kick), .scl(scl_in), .sda(sda_in));

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      $display("run exceeded its cycle ceiling");
      wrap_up();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic kick_host;
    @(posedge ref_clk) kick <= 1'b1;
    @(posedge ref_clk) kick <= 1'b0;
  endtask

  // button press, then hold period measured from release (in cycles)
  task automatic press(input int low, input int hold);
    @(posedge ref_clk) manual_reset_n <= 1'b0;
    cyc(low);
    check(reset_out_n, 1'b0);
    @(posedge ref_clk) manual_reset_n <= 1'b1;
    cyc(hold - 100);
    check(reset_out_n, 1'b0);
    cyc(250);
    check(reset_out_n, 1'b1);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    primary_supply_sense = 1'b1;
    second_supply_sense = 1'b1;
    backup_cell_ok = 1'b1;
    primary_below_batt = 1'b0;
    primary_above_batt = 1'b1;
    supply_above_1v = 1'b1;
    manual_reset_n = 1'b1;
    kick = 1'b0;
    auto_kick = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // rows: status bits read back as live state, code field defaults to off
    rows = '{'{1'b0, REG_CTRL, 32'h0, 32'h1, 32'h0}, '{1'b0, REG_STAT, 32'h0, 32'h33f, 32'h300},
      '{1'b1, 8'h08, 32'hffffffff, 32'h0, 32'h0}, '{1'b0, 8'h08, 32'h0, 32'hffffffff, 32'h0},
      '{1'b1, REG_CTRL, 32'h1, 32'h0, 32'h0}, '{1'b0, REG_CTRL, 32'h0, 32'h1, 32'h1},
      '{1'b1, REG_CTRL, 32'h0, 32'h0, 32'h0}, '{1'b0, REG_CTRL, 32'h0, 32'h1, 32'h0},
      '{1'b1, REG_STAT, 32'h100, 32'h0, 32'h0}, '{1'b0, REG_STAT, 32'h0, 32'h300, 32'h100},
      '{1'b1, REG_STAT, 32'h300, 32'h0, 32'h0}, '{1'b0, REG_STAT, 32'h0, 32'h300, 32'h300}};
    codes = '{2'h2, 2'h1, 2'h0};
    lims = '{150, 400, 800};
    cyc(8);
    check(reset_out_n, 1'b0);
    check(watchdog_expired_n, 1'b1);
    cyc(8);
    rst <= 1'b0;
    cyc(1400);
    check(reset_out_n, 1'b0);
    cyc(200);
    check(reset_out_n, 1'b1);
    $display("test power_on done");
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].data);
      end else begin
        rd(rows[i].addr, got);
        check(got & rows[i].mask, rows[i].exp);
      end
    end
    $display("test registers done");
    // each period: quiet until just before, expired just after, restart clears
    for (int i = 0; i < 3; i++) begin
      wr(REG_STAT, {22'h0, codes[i], 8'h0});
      kick_host();
      cyc((lims[i] - 10) * TK);
      check(watchdog_expired_n, 1'b1);
      cyc(30 * TK);
      check(watchdog_expired_n, 1'b0);
      kick_host();
      cyc(12);
      check(watchdog_expired_n, 1'b1);
    end
    wr(REG_STAT, 32'h200);
    @(posedge ref_clk) auto_kick <= 1'b1;
    cyc(3000);
    check(watchdog_expired_n, 1'b1);
    @(posedge ref_clk) auto_kick <= 1'b0;
    wr(REG_STAT, 32'h300);
    kick_host();
    cyc(200 * TK);
    check(watchdog_expired_n, 1'b1);
    $display("test watchdog done");
    @(posedge ref_clk) second_supply_sense <= 1'b0;
    cyc(6);
    check(second_supply_fail_n, 1'b0);
    @(posedge ref_clk) second_supply_sense <= 1'b1;
    cyc(6);
    check(second_supply_fail_n, 1'b1);
    $display("test second_supply done");
    // let the shortest period expire so backup has something to clear
    wr(REG_STAT, 32'h200);
    cyc(1700);
    check(watchdog_expired_n, 1'b0);
    @(posedge ref_clk) primary_supply_sense <= 1'b0;
    cyc(5);
    check(lowline_n, 1'b0);
    check(reset_out_n, 1'b1);
    cyc(5);
    check(reset_out_n, 1'b0);
    @(posedge ref_clk) primary_below_batt <= 1'b1;
    @(posedge ref_clk) primary_above_batt <= 1'b0;
    cyc(10);
    check(batt_path, 1'b1);
    rd(REG_STAT, got);
    check(got & 32'h21, 32'h21);
    check(watchdog_expired_n, 1'b1);
    wr(REG_STAT, 32'h300);
    @(posedge ref_clk) backup_cell_ok <= 1'b0;
    @(posedge ref_clk) second_supply_sense <= 1'b0;
    cyc(10);
    check(second_supply_fail_n, 1'b1);
    @(posedge ref_clk) second_supply_sense <= 1'b1;
    @(posedge ref_clk) backup_cell_ok <= 1'b1;
    @(posedge ref_clk) supply_above_1v <= 1'b0;
    cyc(10);
    check(reset_out_n, 1'b0);
    @(posedge ref_clk) supply_above_1v <= 1'b1;
    @(posedge ref_clk) primary_below_batt <= 1'b0;
    cyc(10);
    check(batt_path, 1'b1);
    @(posedge ref_clk) primary_above_batt <= 1'b1;
    cyc(10);
    check(batt_path, 1'b0);
    @(posedge ref_clk) primary_supply_sense <= 1'b1;
    cyc(1400);
    check(reset_out_n, 1'b0);
    cyc(200);
    check(reset_out_n, 1'b1);
    // core supply loss with primary good must pull reset at once
    @(posedge ref_clk) supply_above_1v <= 1'b0;
    cyc(6);
    check(reset_out_n, 1'b0);
    @(posedge ref_clk) supply_above_1v <= 1'b1;
    cyc(1600);
    check(reset_out_n, 1'b1);
    $display("test power_down done");
    // a press shorter than one tick must be swallowed
    @(posedge ref_clk) manual_reset_n <= 1'b0;
    cyc(5);
    @(posedge ref_clk) manual_reset_n <= 1'b1;
    cyc(60);
    check(reset_out_n, 1'b1);
    press(60, 1500);
    wr(REG_CTRL, 32'h1);
    press(60, 6000);
    $display("test manual_reset done");
    wrap_up();
  end
endmodule // tb_top
